/* shared/lpc_irq_pkg.sv */
package lpc_irq_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] EVT_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] MASK_OFS = 4'hC;

    // control register fields
    localparam int L11_EN_BIT = 7;
    localparam int L10_EN_BIT = 6;
    localparam int DIRECT_BIT = 0;

    // status register fields
    localparam int ST_FLAG_BIT = 0;
    localparam int ST_L11_OUT_BIT = 1;
    localparam int ST_L10_OUT_BIT = 2;
    localparam int ST_ARM11_BIT = 3;

    // event / mask register fields
    localparam int EVT_W = 3;
    localparam int EVT_RISE_BIT = 0;
    localparam int EVT_FALL_BIT = 1;
    localparam int EVT_LRST_BIT = 2;

    localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
    localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        RESP_OKAY = 2'b00,
        RESP_SLVERR = 2'b10
    } resp_t;
endpackage

/* shared/regbus_if.sv */
`timescale 1ns/1ps
interface regbus_if;
    import lpc_irq_pkg::*;
    logic wr;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic wr_err;
    logic rd;
    logic [ADDR_W-1:0] raddr;
    logic [DATA_W-1:0] rdata;
    logic rd_err;

    modport bus (
        output wr, waddr, wdata, wstrb, rd, raddr,
        input wr_err, rdata, rd_err
    );
    modport core (
        input wr, waddr, wdata, wstrb, rd, raddr,
        output wr_err, rdata, rd_err
    );
endinterface

/* logic/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;

    // the first stage feeds only the second stage
    always_comb begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;
endmodule

/* logic/axil_regs_slave.sv */
`timescale 1ns/1ps
module axil_regs_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [lpc_irq_pkg::ADDR_W-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [lpc_irq_pkg::DATA_W-1:0] wdata_i,
    input wire logic [lpc_irq_pkg::STRB_W-1:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [lpc_irq_pkg::ADDR_W-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [lpc_irq_pkg::DATA_W-1:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    regbus_if.bus rb
);
    import lpc_irq_pkg::*;

    logic aw_have_reg, aw_have_next;
    logic w_have_reg, w_have_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [STRB_W-1:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    resp_t bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    resp_t rresp_reg, rresp_next;
    logic aw_hs, w_hs, ar_hs, wr_fire;

    always_comb begin
        aw_hs = awvalid_i && awready_reg;
        w_hs = wvalid_i && wready_reg;
        ar_hs = arvalid_i && arready_reg;
        // commit only once both halves are held, so address and data may come in any order
        wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (aw_hs) begin
            aw_have_next = 1'b1;
            awaddr_next = awaddr_i;
        end
        if (w_hs) begin
            w_have_next = 1'b1;
            wdata_next = wdata_i;
            wstrb_next = wstrb_i;
        end
        if (bvalid_reg && bready_i) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = rb.wr_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (rvalid_reg && rready_i) begin
            rvalid_next = 1'b0;
        end
        if (ar_hs) begin
            rvalid_next = 1'b1;
            rdata_next = rb.rdata;
            rresp_next = rb.rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;
        arready_next = !rvalid_next;
        rb.wr = wr_fire;
        rb.waddr = awaddr_reg;
        rb.wdata = wdata_reg;
        rb.wstrb = wstrb_reg;
        rb.rd = ar_hs;
        rb.raddr = araddr_i;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign awready_o = awready_reg;
    assign wready_o = wready_reg;
    assign bvalid_o = bvalid_reg;
    assign bresp_o = bresp_reg;
    assign arready_o = arready_reg;
    assign rvalid_o = rvalid_reg;
    assign rdata_o = rdata_reg;
    assign rresp_o = rresp_reg;
endmodule

/* logic/lpc_ch3_host_irq_enable.sv */
`timescale 1ns/1ps
//Behaviour
// - with the line 11 enable set and direct mode off, a rising buffer-full flag requests line 11.
// - with the line 11 enable set and direct mode on, line 11 is requested regardless of the flag.
// - the line 11 enable is set only by writing 1 after software has read it back as 0.
// - the line 10 enable sits at bit 6, resets to 0 and is reachable only from the slave bus.
// - the line 10 enable gates line 10 requests caused by the buffer-full flag being set.
// - while the line 10 enable is 0 no line 10 request is raised at all.
// - a slave write of 0 clears the line 10 enable.
// - an LPC hardware reset or LPC software reset clears the line 10 enable.
// - with direct mode off, the buffer-full flag going to 0 clears the line 10 enable.
// - with the line 10 enable set and direct mode off, a rising flag requests line 10.
module lpc_ch3_host_irq_enable (
    input wire logic SYS_CLK_I,
    input wire logic RESET_I,
    input wire logic [lpc_irq_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [lpc_irq_pkg::DATA_W-1:0] S_AXI_WDATA_I,
    input wire logic [lpc_irq_pkg::STRB_W-1:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [lpc_irq_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [lpc_irq_pkg::DATA_W-1:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic CH3_OUTPUT_BUFFER_FULL_FLAG_I,
    input wire logic LPC_CLK_I,
    input wire logic LPC_HW_RESET_N_I,
    input wire logic LPC_SW_RESET_I,
    output logic HOST_IRQ_LINE_11_O,
    output logic HOST_IRQ_LINE_10_O,
    output logic IRQ_O
);
    import lpc_irq_pkg::*;

    localparam int SYNC_W = 3;
    localparam int SY_CLK = 0;
    localparam int SY_HWRST_N = 1;
    localparam int SY_SWRST = 2;

    regbus_if rb ();

    axil_regs_slave u_axil (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .awaddr_i(S_AXI_AWADDR_I),
        .awvalid_i(S_AXI_AWVALID_I),
        .awready_o(S_AXI_AWREADY_O),
        .wdata_i(S_AXI_WDATA_I),
        .wstrb_i(S_AXI_WSTRB_I),
        .wvalid_i(S_AXI_WVALID_I),
        .wready_o(S_AXI_WREADY_O),
        .bresp_o(S_AXI_BRESP_O),
        .bvalid_o(S_AXI_BVALID_O),
        .bready_i(S_AXI_BREADY_I),
        .araddr_i(S_AXI_ARADDR_I),
        .arvalid_i(S_AXI_ARVALID_I),
        .arready_o(S_AXI_ARREADY_O),
        .rdata_o(S_AXI_RDATA_O),
        .rresp_o(S_AXI_RRESP_O),
        .rvalid_o(S_AXI_RVALID_O),
        .rready_i(S_AXI_RREADY_I),
        .rb(rb.bus)
    );

    logic [SYNC_W-1:0] pins_sync;

    pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_i(SYS_CLK_I),
        .rst_i(RESET_I),
        .async_i({LPC_SW_RESET_I, LPC_HW_RESET_N_I, LPC_CLK_I}),
        .sync_o(pins_sync)
    );

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = (addr == CTRL_OFS) || (addr == STAT_OFS) ||
                    (addr == EVT_OFS) || (addr == MASK_OFS);
    endfunction

    logic host_line11_irq_enable_reg, host_line11_irq_enable_next;
    logic host_line10_irq_enable_reg, host_line10_irq_enable_next;
    logic irq_direct_request_select_reg, irq_direct_request_select_next;
    logic arm11_reg, arm11_next;
    logic flag_d_reg, flag_d_next;
    logic lclk_d_reg, lclk_d_next;
    logic lpc_rst_d_reg, lpc_rst_d_next;
    logic line11_out_reg, line11_out_next;
    logic line10_out_reg, line10_out_next;
    logic [EVT_W-1:0] evt_reg, evt_next;
    logic [EVT_W-1:0] mask_reg, mask_next;
    logic irq_reg, irq_next;
    logic flag, flag_rose, flag_fell, lpc_rst, lclk_rise;
    logic req11, req10, ctrl_wr;
    logic [EVT_W-1:0] evt_set;

    always_comb begin
        flag = CH3_OUTPUT_BUFFER_FULL_FLAG_I;
        flag_rose = flag && !flag_d_reg;
        flag_fell = !flag && flag_d_reg;
        lpc_rst = !pins_sync[SY_HWRST_N] || pins_sync[SY_SWRST];
        lclk_rise = pins_sync[SY_CLK] && !lclk_d_reg;
        ctrl_wr = rb.wr && (rb.waddr == CTRL_OFS) && rb.wstrb[0];
        // direct mode drops the flag term; otherwise the flag level drives the line
        req11 = host_line11_irq_enable_reg && (irq_direct_request_select_reg || flag);
        req10 = host_line10_irq_enable_reg && (irq_direct_request_select_reg || flag);
        evt_set = '0;
        evt_set[EVT_RISE_BIT] = flag_rose;
        evt_set[EVT_FALL_BIT] = flag_fell;
        evt_set[EVT_LRST_BIT] = lpc_rst && !lpc_rst_d_reg;
    end

    // register read mux; reserved bits read as zero
    always_comb begin
        rb.rdata = RDATA_ZERO;
        rb.rd_err = !is_mapped(rb.raddr);
        rb.wr_err = !is_mapped(rb.waddr);
        case (rb.raddr)
            CTRL_OFS: begin
                rb.rdata[L11_EN_BIT] = host_line11_irq_enable_reg;
                rb.rdata[L10_EN_BIT] = host_line10_irq_enable_reg;
                rb.rdata[DIRECT_BIT] = irq_direct_request_select_reg;
            end
            STAT_OFS: begin
                rb.rdata[ST_FLAG_BIT] = flag;
                rb.rdata[ST_L11_OUT_BIT] = line11_out_reg;
                rb.rdata[ST_L10_OUT_BIT] = line10_out_reg;
                rb.rdata[ST_ARM11_BIT] = arm11_reg;
            end
            EVT_OFS: begin
                rb.rdata[EVT_W-1:0] = evt_reg;
            end
            MASK_OFS: begin
                rb.rdata[EVT_W-1:0] = mask_reg;
            end
            default: begin
                rb.rdata = RDATA_ZERO;
            end
        endcase
    end

    always_comb begin
        host_line11_irq_enable_next = host_line11_irq_enable_reg;
        host_line10_irq_enable_next = host_line10_irq_enable_reg;
        irq_direct_request_select_next = irq_direct_request_select_reg;
        arm11_next = arm11_reg;
        mask_next = mask_reg;
        evt_next = evt_reg;
        if (rb.rd && (rb.raddr == CTRL_OFS) && !host_line11_irq_enable_reg) begin
            arm11_next = 1'b1;
        end
        if (rb.rd && (rb.raddr == EVT_OFS)) begin
            evt_next = '0;
        end
        if (ctrl_wr) begin
            host_line10_irq_enable_next = rb.wdata[L10_EN_BIT];
            irq_direct_request_select_next = rb.wdata[DIRECT_BIT];
            if (!rb.wdata[L11_EN_BIT]) begin
                host_line11_irq_enable_next = 1'b0;
            end else if (arm11_reg) begin
                host_line11_irq_enable_next = 1'b1;
            end
            // a write consumes the read-back; a second 1 needs a fresh read of 0
            arm11_next = 1'b0;
        end
        if (rb.wr && (rb.waddr == MASK_OFS) && rb.wstrb[0]) begin
            mask_next = rb.wdata[EVT_W-1:0];
        end
        // hardware clears beat a simultaneous software set
        if (flag_fell && !irq_direct_request_select_reg) begin
            host_line11_irq_enable_next = 1'b0;
            host_line10_irq_enable_next = 1'b0;
        end
        if (lpc_rst) begin
            host_line11_irq_enable_next = 1'b0;
            host_line10_irq_enable_next = 1'b0;
        end
        // an event in the clearing read's cycle survives
        evt_next = evt_next | evt_set;
        irq_next = |(evt_reg & mask_reg);
        flag_d_next = flag;
        lpc_rst_d_next = lpc_rst;
        lclk_d_next = pins_sync[SY_CLK];
        // lines change only on a host clock rise so the host never sees a mid-cycle step;
        // costs up to one host clock of latency
        line11_out_next = lclk_rise ? req11 : line11_out_reg;
        line10_out_next = lclk_rise ? req10 : line10_out_reg;
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            host_line11_irq_enable_reg <= 1'b0;
            host_line10_irq_enable_reg <= 1'b0;
            irq_direct_request_select_reg <= 1'b0;
            arm11_reg <= 1'b0;
            mask_reg <= MASK_RST;
            evt_reg <= EVT_RST;
            irq_reg <= 1'b0;
            flag_d_reg <= 1'b0;
            lpc_rst_d_reg <= 1'b0;
            lclk_d_reg <= 1'b0;
            line11_out_reg <= 1'b0;
            line10_out_reg <= 1'b0;
        end else begin
            host_line11_irq_enable_reg <= host_line11_irq_enable_next;
            host_line10_irq_enable_reg <= host_line10_irq_enable_next;
            irq_direct_request_select_reg <= irq_direct_request_select_next;
            arm11_reg <= arm11_next;
            mask_reg <= mask_next;
            evt_reg <= evt_next;
            irq_reg <= irq_next;
            flag_d_reg <= flag_d_next;
            lpc_rst_d_reg <= lpc_rst_d_next;
            lclk_d_reg <= lclk_d_next;
            line11_out_reg <= line11_out_next;
            line10_out_reg <= line10_out_next;
        end
    end

    assign HOST_IRQ_LINE_11_O = line11_out_reg;
    assign HOST_IRQ_LINE_10_O = line10_out_reg;
    assign IRQ_O = irq_reg;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    chk_l11_flag_req: assert property (
        $rose(flag) && host_line11_irq_enable_reg && !irq_direct_request_select_reg
        |-> ##[1:16] (HOST_IRQ_LINE_11_O || !req11))
        else $error("line 11 not raised after flag rise");

    chk_l11_direct: assert property (
        $rose(host_line11_irq_enable_reg && irq_direct_request_select_reg)
        |-> ##[1:16] (HOST_IRQ_LINE_11_O || !req11))
        else $error("line 11 not raised in direct mode");

    chk_l11_set_armed: assert property (
        $rose(host_line11_irq_enable_reg) |-> $past(arm11_reg) && $past(ctrl_wr))
        else $error("line 11 enable set without prior read of 0");

    chk_l10_readback: assert property (
        rb.rd && rb.raddr == CTRL_OFS |-> ##1 S_AXI_RVALID_O &&
        S_AXI_RDATA_O[L10_EN_BIT] == $past(host_line10_irq_enable_reg))
        else $error("line 10 enable read back wrong");

    chk_l10_gated: assert property (
        $rose(HOST_IRQ_LINE_10_O) |-> $past(host_line10_irq_enable_reg))
        else $error("line 10 raised while disabled");

    chk_l10_wr_zero: assert property (
        ctrl_wr && !rb.wdata[L10_EN_BIT] |=> !host_line10_irq_enable_reg)
        else $error("write of 0 did not clear line 10 enable");

    chk_l10_lpc_reset: assert property (
        lpc_rst |=> !host_line10_irq_enable_reg && !host_line11_irq_enable_reg)
        else $error("LPC reset did not clear enables");

    chk_l10_flag_clear: assert property (
        $fell(flag) && !irq_direct_request_select_reg |=> !host_line10_irq_enable_reg)
        else $error("flag clear did not clear line 10 enable");

    chk_l10_flag_req: assert property (
        $rose(flag) && host_line10_irq_enable_reg && !irq_direct_request_select_reg
        |-> ##[1:16] (HOST_IRQ_LINE_10_O || !req10))
        else $error("line 10 not raised after flag rise");

    chk_l10_direct: assert property (
        $rose(host_line10_irq_enable_reg && irq_direct_request_select_reg)
        |-> ##[1:16] (HOST_IRQ_LINE_10_O || !req10))
        else $error("line 10 not raised in direct mode");

    chk_irq_mask_out: assert property (
        ##1 IRQ_O == $past(|(evt_reg & mask_reg)))
        else $error("interrupt output does not follow masked events");
endmodule

/* tb/lpc_host_model.sv */
`timescale 1ns/1ps
module lpc_host_model (
    input wire logic line11_i,
    input wire logic line10_i,
    input wire logic hw_req_i,
    input wire logic sw_req_i,
    output logic lpc_clk_o,
    output logic hw_reset_n_o,
    output logic sw_reset_o,
    output logic seen11_o,
    output logic seen10_o
);
    // the link clock runs free: no serial frames are modelled, only the host's view of the lines
    initial begin
        lpc_clk_o = 1'b0;
        seen11_o = 1'b0;
        seen10_o = 1'b0;
        #57;
        forever begin
            #160 lpc_clk_o = ~lpc_clk_o;
        end
    end
    // the host samples the request lines once per link clock, as a slow observer would
    always @(posedge lpc_clk_o) begin
        seen11_o <= line11_i;
        seen10_o <= line10_i;
    end
    // resets are asserted a little after the request, off any system clock edge
    // continuous so the pins hold a known level from 13 ns on, whatever order the processes begin in
    assign #13 hw_reset_n_o = ~hw_req_i;
    assign #13 sw_reset_o = sw_req_i;
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench;
    import lpc_irq_pkg::*;
    logic clk, rst, awv, wv, bready, arv, rready, flag, hwq, swq;
    logic awrdy, wrdy, bvalid, arrdy, rvalid, l11, l10, irq, lclk, hwn, swr, s11, s10;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, d;
    logic [STRB_W-1:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [31:0] st, v;
    int mismatches, checks_done;
    logic [7:0] tab [5] = '{8'h00, 8'hC0, 8'h80, 8'hC1, 8'h41};
    logic [2:0] exp [5] = '{3'b100, 3'b111, 3'b110, 3'b011, 3'b001};

    lpc_ch3_host_irq_enable u_lpc_ch3_host_irq_enable (.SYS_CLK_I(clk), .RESET_I(rst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv),
        .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arrdy), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .CH3_OUTPUT_BUFFER_FULL_FLAG_I(flag), .LPC_CLK_I(lclk), .LPC_HW_RESET_N_I(hwn),
        .LPC_SW_RESET_I(swr), .HOST_IRQ_LINE_11_O(l11), .HOST_IRQ_LINE_10_O(l10), .IRQ_O(irq));
    lpc_host_model u_lpc_host_model (.line11_i(l11), .line10_i(l10), .hw_req_i(hwq),
        .sw_req_i(swq), .lpc_clk_o(lclk), .hw_reset_n_o(hwn), .sw_reset_o(swr),
        .seen11_o(s11), .seen10_o(s10));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction

    // ready and valid are read at the falling edge, where registered outputs are settled
    task automatic wr(input logic [3:0] a, input logic [31:0] dt, output logic [1:0] rs);
        logic ta, tw, bd;
        @(posedge clk);
        awaddr <= a;
        wdata <= dt;
        wstrb <= 4'hF;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awv & awrdy;
            tw = wv & wrdy;
            bd = bvalid;
            rs = bresp;
            @(posedge clk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (!bd);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] dt, output logic [1:0] rs);
        logic ta, rv;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arv & arrdy;
            rv = rvalid;
            dt = rdata;
            rs = rresp;
            @(posedge clk);
            if (ta) arv <= 1'b0;
        end while (!rv);
        rready <= 1'b0;
    endtask

    // clear, read back as zero so the line 11 enable may be set, then write the wanted value
    task automatic en(input logic [7:0] c);
        wr(CTRL_OFS, 32'h0, r);
        rd(CTRL_OFS, d, r);
        wr(CTRL_OFS, {24'h0, c}, r);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out();
    end

    initial begin
        st = 32'd35;
        rst = 1'b1;
        {awv, wv, bready, arv, rready, flag, hwq, swq} = 8'h00;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        rd(EVT_OFS, d, r);
        `CHK("evt_lrst", 1'b1, d[EVT_LRST_BIT])
        rd(CTRL_OFS, d, r);
        `CHK("ctrl_rst", 8'h00, d[7:0] & 8'hC1)
        wr(CTRL_OFS, 32'h0, r);
        wr(CTRL_OFS, 32'h80, r);
        rd(CTRL_OFS, d, r);
        `CHK("l11_unarmed", 1'b0, d[L11_EN_BIT])
        wr(CTRL_OFS, 32'h80, r);
        rd(CTRL_OFS, d, r);
        `CHK("l11_armed", 1'b1, d[L11_EN_BIT])
        wr(CTRL_OFS, 32'h40, r);
        rd(CTRL_OFS, d, r);
        `CHK("l10_set", 8'h40, d[7:0] & 8'hC1)
        wr(CTRL_OFS, 32'h0, r);
        rd(CTRL_OFS, d, r);
        `CHK("l10_clr", 1'b0, d[L10_EN_BIT])
        for (int i = 0; i < 5; i++) begin
            en(tab[i]);
            flag <= exp[i][2];
            repeat (28) @(posedge clk);
            `CHK("host_lines", exp[i][1:0], {s11, s10})
            `CHK("pin_lines", exp[i][1:0], {l11, l10})
            rd(STAT_OFS, d, r);
            `CHK("status", {1'b0, exp[i][0], exp[i][1], exp[i][2]}, d[3:0])
            `CHK("status_resp", RESP_OKAY, r)
            flag <= 1'b0;
            repeat (4) @(posedge clk);
        end
        foreach (tab[i]) if (i == 1 || i == 4) begin
            en(tab[i]);
            flag <= 1'b1;
            repeat (4) @(posedge clk);
            flag <= 1'b0;
            repeat (4) @(posedge clk);
            rd(CTRL_OFS, d, r);
            `CHK("flag_fall", (tab[i][0] ? tab[i] : 8'h00), d[7:0] & 8'hC1)
        end
        for (int k = 0; k < 2; k++) begin
            en(8'h40);
            if (k == 0) hwq <= 1'b1;
            else swq <= 1'b1;
            repeat (8) @(posedge clk);
            {hwq, swq} <= 2'b00;
            repeat (8) @(posedge clk);
            rd(CTRL_OFS, d, r);
            `CHK("lpc_reset", 1'b0, d[L10_EN_BIT])
        end
        wr(MASK_OFS, 32'h1, r);
        rd(EVT_OFS, d, r);
        flag <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("irq_on", 1'b1, irq)
        rd(EVT_OFS, d, r);
        `CHK("evt_rise", 1'b1, d[EVT_RISE_BIT])
        repeat (3) @(posedge clk);
        `CHK("irq_off", 1'b0, irq)
        wr(MASK_OFS, 32'h0, r);
        flag <= 1'b0;
        repeat (4) @(posedge clk);
        `CHK("irq_masked", 1'b0, irq)
        rd(EVT_OFS, d, r);
        `CHK("evt_fall", 1'b1, d[EVT_FALL_BIT])
        rd(4'h6, d, r);
        `CHK("rd_unmapped", RESP_SLVERR, r)
        wr(4'h6, 32'hFF, r);
        `CHK("wr_unmapped", RESP_SLVERR, r)
        repeat (4) begin
            v = xs();
            wr(MASK_OFS, v, r);
            rd(MASK_OFS, d, r);
            `CHK("mask_rb", {29'h0, v[2:0]}, d)
        end
        close_out();
    end
endmodule
